// ==== verilog/trc_timer.sv ====
// 16-bit auto-reload / capture timer with AXI4-Lite register access
//
// Overview of operation
// - The count is 16 bits and the timer runs either in auto-reload or in capture mode.
// - With the prescaler on the count advances once every twelve clock cycles.
// - The count keeps running through overflow and reload while enabled.
// - Auto-reload without up/down counts up from the reload value and overflows past FFFF.
// - Auto-reload without up/down reloads on overflow, or also on a chosen pin edge.
// - Every auto-reload event except an underflow loads the software-written reload/capture value.
// - Auto-reload without up/down raises an interrupt request on every reload.
// - With up/down enabled the pin level picks the direction, high up and low down.
// - With up/down enabled no interrupt request is raised on reload.
// - Counting up with up/down enabled reloads from the register on passing FFFF.
// - Counting down, reaching the register value underflows and reloads FFFF.
// - Capture mode counts up from 0000 and reloads 0000 on passing FFFF.
// - In capture mode a chosen pin edge copies the count into the register.
// - In capture mode overflow or capture raises an interrupt request.
// - The capture result between edges serves to measure an incoming bit time.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module trc_timer
  import trc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // External trigger / direction pin
  input  wire logic        external_trigger_pin,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt
  output logic             irq
);
  import trc_pkg::*;

  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic [15:0]           timer_count_16_r;
  logic [15:0]           reload_capture_value_r;
  logic [15:0]           bit_time_r;
  logic [15:0]           last_capture_r;
  logic [STAT_WIDTH-1:0] status_r;
  logic [STAT_WIDTH-1:0] mask_r;
  logic [3:0]            div_r;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  trc_edge_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (clk_en),
    .pin_in  (external_trigger_pin),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  logic run;
  logic cap_mode;
  logic updown;
  logic ext_en;
  logic sel_edge;
  logic tick;
  logic count_up;
  logic ovf;
  logic unf;
  logic ext_reload;
  logic reload_ev;
  logic capture_ev;
  logic [15:0] count_nxt;

  assign run      = ctrl_r[CTRL_RUN_BIT];
  assign cap_mode = ctrl_r[CTRL_CAPMODE_BIT];
  assign updown   = ctrl_r[CTRL_UPDOWN_BIT] & ~cap_mode;
  assign ext_en   = ctrl_r[CTRL_EXTEN_BIT];
  assign sel_edge = ctrl_r[CTRL_RISING_BIT] ? pin_rise : pin_fall;

  // Prescaler on divides by twelve; off (CTRL_PREDIS_BIT set) passes every clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 4'h0;
    end else if (clk_en) begin
      if (!run || div_r == DIV_COUNT - 4'h1) begin
        div_r <= 4'h0;
      end else begin
        div_r <= div_r + 4'h1;
      end
    end
  end

  assign tick = clk_en & run &
                (ctrl_r[CTRL_PREDIS_BIT] ? 1'b1 : (div_r == DIV_COUNT - 4'h1));

  assign count_up   = ~updown | pin_level;
  assign ovf        = tick & count_up & (timer_count_16_r == COUNT_TOP);
  assign unf        = tick & ~count_up & (timer_count_16_r == reload_capture_value_r);
  // Pin-triggered reload only exists without up/down, in auto-reload mode
  assign ext_reload = clk_en & run & ~cap_mode & ~updown & ext_en & sel_edge;
  assign reload_ev  = ovf | unf | ext_reload;
  assign capture_ev = clk_en & run & cap_mode & sel_edge;

  always_comb begin
    count_nxt = timer_count_16_r;
    if (cap_mode) begin
      if (ovf) begin
        count_nxt = COUNT_ZERO;
      end else if (tick) begin
        count_nxt = timer_count_16_r + 16'h0001;
      end
    end else if (ovf || ext_reload) begin
      count_nxt = reload_capture_value_r;
    end else if (unf) begin
      count_nxt = COUNT_TOP;
    end else if (tick) begin
      count_nxt = count_up ? timer_count_16_r + 16'h0001
                           : timer_count_16_r - 16'h0001;
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic [15:0] wr_half;

  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign wr_go         = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_half       = {wstrb_r[1] ? wdata_r[15:8] : 8'h00,
                          wstrb_r[0] ? wdata_r[7:0] : 8'h00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_r)
          CTRL_OFS, RELOAD_OFS, COUNT_OFS, STATUS_OFS, MASK_OFS, BITTIME_OFS:
            s_axi_bresp <= RESP_OKAY;
          default:
            s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl;
  logic wr_reload;
  logic wr_count;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl   = wr_go & (awaddr_r == CTRL_OFS) & wstrb_r[0];
  assign wr_reload = wr_go & (awaddr_r == RELOAD_OFS) & (|wstrb_r[1:0]);
  assign wr_count  = wr_go & (awaddr_r == COUNT_OFS) & (|wstrb_r[1:0]);
  assign wr_status = wr_go & (awaddr_r == STATUS_OFS) & wstrb_r[0];
  assign wr_mask   = wr_go & (awaddr_r == MASK_OFS) & wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      mask_r <= '0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[CTRL_WIDTH-1:0];
      end
      if (wr_mask) begin
        mask_r <= wdata_r[STAT_WIDTH-1:0];
      end
    end
  end

  // Count keeps running through reloads; software write overrides one step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count_16_r <= COUNT_ZERO;
    end else if (clk_en) begin
      if (wr_count) begin
        timer_count_16_r <= wr_half;
      end else if (wr_ctrl && wdata_r[CTRL_CAPMODE_BIT] && !cap_mode) begin
        timer_count_16_r <= COUNT_ZERO;
      end else begin
        timer_count_16_r <= count_nxt;
      end
    end
  end

  // Capture wins over a software write in the same cycle so no edge is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_capture_value_r <= RELOAD_RST;
      last_capture_r         <= COUNT_ZERO;
      bit_time_r             <= COUNT_ZERO;
    end else if (clk_en) begin
      if (capture_ev) begin
        reload_capture_value_r <= timer_count_16_r;
        last_capture_r         <= timer_count_16_r;
        bit_time_r             <= timer_count_16_r - last_capture_r;
      end else if (wr_reload) begin
        reload_capture_value_r <= wr_half;
      end
    end
  end

  logic [STAT_WIDTH-1:0] stat_set;

  always_comb begin
    stat_set = '0;
    stat_set[STAT_RELOAD_BIT]  = reload_ev & ~updown;
    stat_set[STAT_CAPTURE_BIT] = capture_ev;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else if (clk_en) begin
      status_r <= (status_r & ~(wr_status ? wdata_r[STAT_WIDTH-1:0] : '0)) | stat_set;
    end
  end

  assign irq = |(status_r & mask_r);

  // AXI4-Lite read channel
  logic [31:0] rd_val;
  logic        rd_ok;

  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      CTRL_OFS:    rd_val[CTRL_WIDTH-1:0] = ctrl_r;
      RELOAD_OFS:  rd_val[15:0] = reload_capture_value_r;
      COUNT_OFS:   rd_val[15:0] = timer_count_16_r;
      STATUS_OFS:  rd_val[STAT_WIDTH-1:0] = status_r;
      MASK_OFS:    rd_val[STAT_WIDTH-1:0] = mask_r;
      BITTIME_OFS: rd_val[15:0] = bit_time_r;
      default:     rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== include/trc_pkg.sv ====
// Package for the 16-bit reload/capture timer: register map, fields and constants
package trc_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] RELOAD_OFS    = 8'h04;
  localparam logic [7:0] COUNT_OFS     = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0c;
  localparam logic [7:0] MASK_OFS      = 8'h10;
  localparam logic [7:0] BITTIME_OFS   = 8'h14;

  // Control fields
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_CAPMODE_BIT = 1;
  localparam int CTRL_UPDOWN_BIT  = 2;
  localparam int CTRL_EXTEN_BIT   = 3;
  localparam int CTRL_RISING_BIT  = 4;
  localparam int CTRL_PREDIS_BIT  = 5;
  localparam int CTRL_WIDTH       = 6;

  // Status / mask fields
  localparam int STAT_RELOAD_BIT  = 0;
  localparam int STAT_CAPTURE_BIT = 1;
  localparam int STAT_WIDTH       = 2;

  // Reset values and fixed counts
  localparam logic [CTRL_WIDTH-1:0] CTRL_RST   = 6'h00;
  localparam logic [15:0]           RELOAD_RST = 16'h0000;
  localparam logic [15:0]           COUNT_TOP  = 16'hffff;
  localparam logic [15:0]           COUNT_ZERO = 16'h0000;
  localparam logic [3:0]            DIV_COUNT  = 4'hc;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== verilog/trc_edge_sync.sv ====
// Two-flop synchroniser with edge detection for the external trigger pin
`timescale 1ns/1ps
module trc_edge_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Pin and results
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic       meta_r;
  logic       sync_r;
  logic       prev_r;
  logic [2:0] fill_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      fill_r <= 3'h0;
    end else if (ce) begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // Edges only seen from the settled copies, never the first flop
  // Reset copies need not match the pin's idle level, so edges wait for a refill
  assign level = sync_r;
  assign rise  = ce & fill_r[2] & sync_r & ~prev_r;
  assign fall  = ce & fill_r[2] & ~sync_r & prev_r;
endmodule

// ==== sim/trc_pin_model.sv ====
// Far-side driver of the trigger pin
`timescale 1ns/1ps
module trc_pin_model (
  // Clock
  input  wire logic aclk,
  // Requested level and pin
  input  wire logic want,
  output logic      pin
);
  initial pin = 1'b1;
  // A push-pull source is never released, so it always shows its level
  always @(posedge aclk) pin <= want;
endmodule

// ==== sim/trc_properties.sv ====
// Bus handshake properties of the reload/capture timer
`timescale 1ns/1ps
module trc_properties
  import trc_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_ans; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_rd_ans; s_rd |-> ##[1:2] s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_bad; s_rd ##0 (s_axi_araddr > BITTIME_OFS || s_axi_araddr[1:0] != 2'b00)
    |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0); endproperty
  a_bad: assert property (p_bad) else $error("unmapped read answered");
  property p_ok; s_rd ##0 (s_axi_araddr <= BITTIME_OFS && s_axi_araddr[1:0] == 2'b00)
    |-> ##[1:2] (s_axi_rvalid
    && s_axi_rresp == RESP_OKAY); endproperty
  a_ok: assert property (p_ok) else $error("mapped read refused");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("bvalid held");
  property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("rvalid held");
  property p_aw_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_blk: assert property (p_aw_blk) else $error("write taken early");
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("read taken early");
endmodule
bind trc_timer trc_properties u_props (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready)
);

// ==== sim/tb_top.sv ====
// Self-checking bench for the reload/capture timer
`timescale 1ns/1ps
module tb_top;
  import trc_pkg::*;
  logic             aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, want = 1'b1;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0, v;
  logic [3:0]       s_axi_wstrb = 4'hf;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ha, hw, hb;
  logic [1:0]       rb;
  wire logic        external_trigger_pin, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic        s_axi_arready, s_axi_rvalid, irq;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int               miscompares = 0, cmp_count = 0, seed = 25, n;
  logic [31:0]      lo_q[$], hi_q[$];
  always #2.5 aclk = ~aclk;
  trc_pin_model u_pin (.aclk(aclk), .want(want), .pin(external_trigger_pin));
  trc_timer u_dut (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .clk_en               (clk_en),
    .external_trigger_pin (external_trigger_pin),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .irq                  (irq)
  );
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, lo, hi);
    cmp_count++;
    if (((seen >= lo) && (seen <= hi)) !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, seen);
    end
  endtask
  task automatic hang();
    miscompares++;
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      hb = s_axi_bvalid;
      rb = s_axi_bresp;
      @(posedge aclk);
      if (ha === 1'b1) s_axi_awvalid <= 1'b0;
      if (hw === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (hb !== 1'b1 && n < 60);
    s_axi_bready <= 1'b0;
    if (hb !== 1'b1) hang();
    chk("bresp", rb, r, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, hi,
                    input logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ha = s_axi_arready;
      hb = s_axi_rvalid;
      rb = s_axi_rresp;
      @(posedge aclk);
      if (ha === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (hb !== 1'b1 && n < 60);
    s_axi_rready <= 1'b0;
    if (hb !== 1'b1) hang();
    chk("rresp", rb, r, r);
  endtask
  task automatic ir(input logic e);
    @(negedge aclk);
    chk("irq", irq, e, e);
  endtask
  // Read data is judged where it is handed over, against the oldest note
  always @(negedge aclk)
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && lo_q.size() > 0)
      chk("rdata", s_axi_rdata, lo_q.pop_front(), hi_q.pop_front());
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RELOAD_OFS, RELOAD_RST, RELOAD_RST);
    rd(8'h18, 32'h0, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h5, RESP_SLVERR);
    wr(CTRL_OFS, 32'h01, RESP_OKAY);
    wr(COUNT_OFS, 32'h0100, RESP_OKAY);
    repeat (480) @(posedge aclk);
    rd(COUNT_OFS, 32'h0127, 32'h012a);
    v = 32'hff00 | ($random(seed) & 32'h7f);
    wr(RELOAD_OFS, v, RESP_OKAY);
    wr(MASK_OFS, 32'h3, RESP_OKAY);
    wr(CTRL_OFS, 32'h21, RESP_OKAY);
    wr(COUNT_OFS, 32'hfff0, RESP_OKAY);
    repeat (40) @(posedge aclk);
    rd(COUNT_OFS, v + 20, v + 35);
    rd(STATUS_OFS, 32'h1, 32'h1);
    ir(1'b1);
    wr(STATUS_OFS, 32'h1, RESP_OKAY);
    ir(1'b0);
    wr(MASK_OFS, 32'h2, RESP_OKAY);
    repeat (300) @(posedge aclk);
    ir(1'b0);
    rd(STATUS_OFS, 32'h1, 32'h1);
    wr(MASK_OFS, 32'h3, RESP_OKAY);
    wr(RELOAD_OFS, 32'h1234, RESP_OKAY);
    for (int e = 0; e < 2; e++) begin
      wr(CTRL_OFS, 32'h29 | (e << 4), RESP_OKAY);
      wr(COUNT_OFS, 32'h0, RESP_OKAY);
      want <= e[0];
      repeat (20) @(posedge aclk);
      rd(COUNT_OFS, 32'h1240, 32'h124c);
    end
    wr(STATUS_OFS, 32'h3, RESP_OKAY);
    want <= 1'b0;
    wr(RELOAD_OFS, 32'h0100, RESP_OKAY);
    wr(CTRL_OFS, 32'h25, RESP_OKAY);
    wr(COUNT_OFS, 32'h0105, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(COUNT_OFS, 32'hffe8, 32'hfff0);
    want <= 1'b1;
    rd(STATUS_OFS, 32'h0, 32'h0);
    ir(1'b0);
    wr(COUNT_OFS, 32'hfffc, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(COUNT_OFS, 32'h0110, 32'h011a);
    rd(STATUS_OFS, 32'h0, 32'h0);
    want <= 1'b0;
    wr(CTRL_OFS, 32'h33, RESP_OKAY);
    repeat (50) @(posedge aclk);
    want <= 1'b1;
    repeat (40) @(posedge aclk);
    want <= 1'b0;
    repeat (40) @(posedge aclk);
    want <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(BITTIME_OFS, 32'h50, 32'h50);
    rd(RELOAD_OFS, 32'h80, 32'h90);
    rd(STATUS_OFS, 32'h2, 32'h2);
    ir(1'b1);
    wr(STATUS_OFS, 32'h3, RESP_OKAY);
    wr(COUNT_OFS, 32'hfff0, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(COUNT_OFS, 32'h8, 32'h19);
    rd(STATUS_OFS, 32'h1, 32'h1);
    // Count must hold while the clock enable is low
    wr(COUNT_OFS, 32'h2000, RESP_OKAY);
    clk_en <= 1'b0;
    repeat (200) @(posedge aclk);
    clk_en <= 1'b1;
    rd(COUNT_OFS, 32'h2002, 32'h2004);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(COUNT_OFS, 32'h0, 32'h0);
    rd(CTRL_OFS, 32'h0, 32'h0);
    final_report();
  end
endmodule
